// [ctz_orbit_engine.sv]
// collatz orbit engine: byte pins, shared busy line and axi4-lite slave
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module ctz_orbit_engine (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // byte port
  input wire logic [7:0] dataIn,
  input wire logic [4:0] addrIn,
  input wire logic selIn,
  input wire logic startIn,
  output logic [7:0] dataOut,
  // shared write enable / busy line
  input wire logic weBusyIn,
  output logic weBusyOut,
  output logic weBusyOe,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  ctz_pkg::ctz_core_s st_reg;
  ctz_pkg::ctz_core_s st_next;

  ctz_pin_if #(.W(ctz_pkg::PIN_W)) pins ();

  // pins come from the host's domain
  // own busy drive masked, else its late echo reads as a fresh write after short runs
  assign pins.raw = {weBusyIn && !st_reg.busyOe, startIn, selIn, addrIn, dataIn};

  ctz_pin_sync #(.W(ctz_pkg::PIN_W)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .pins(pins)
  );

  logic [7:0] pinData;
  logic [4:0] pinAddr;
  logic pinSel;
  logic pinStart;
  logic pinWe;
  logic weRise;
  logic startRise;
  logic [143:0] stepVal;
  logic isDone;

  assign pinData = pins.clean[ctz_pkg::PIN_DATA_LSB +: 8];
  assign pinAddr = pins.clean[ctz_pkg::PIN_ADDR_LSB +: 5];
  assign pinSel = pins.clean[ctz_pkg::PIN_SEL];
  assign pinStart = pins.clean[ctz_pkg::PIN_START];
  assign pinWe = pins.clean[ctz_pkg::PIN_WE];
  assign weRise = pinWe && !st_reg.weSeen;
  assign startRise = pinStart && !st_reg.startSeen;
  // zero would halve forever, so it ends the run like one
  assign isDone = (st_reg.iter == ctz_pkg::ITER_ONE) || (st_reg.iter == ctz_pkg::RST_ITER);
  // wraps past 144 bits; the peak field only sees the top word
  assign stepVal = st_reg.iter[0] ?
    ({st_reg.iter[142:0], 1'b0} + st_reg.iter + ctz_pkg::ITER_ONE) :
    {1'b0, st_reg.iter[143:1]};

  always_comb begin
    logic doStart;
    logic axiLoad;
    logic [4:0] ldAddr;
    logic [7:0] ldData;
    logic [15:0] topWord;
    logic [15:0] result;
    logic [7:0] rdAddr;
    doStart = 1'b0;
    axiLoad = 1'b0;
    ldAddr = st_reg.wData[ctz_pkg::LOAD_ADDR_LSB +: 5];
    ldData = st_reg.wData[ctz_pkg::LOAD_DATA_LSB +: 8];
    topWord = stepVal[ctz_pkg::ITER_W-1:ctz_pkg::PEAK_LSB];
    result = ctz_pkg::RST_RESULT;
    rdAddr = araddr;
    st_next = st_reg;
    st_next.weSeen = pinWe;
    st_next.startSeen = pinStart;

    // axi write channels, taken in either order
    if (awvalid && st_reg.awRdy) begin
      st_next.awHave = 1'b1;
      st_next.awAddr = awaddr;
      st_next.awRdy = 1'b0;
    end
    if (wvalid && st_reg.wRdy) begin
      st_next.wHave = 1'b1;
      st_next.wData = wdata;
      st_next.wStrb = wstrb;
      st_next.wRdy = 1'b0;
    end
    if (st_reg.awHave && st_reg.wHave && !st_reg.bValid) begin
      st_next.awHave = 1'b0;
      st_next.wHave = 1'b0;
      st_next.bValid = 1'b1;
      st_next.bResp = ctz_pkg::RESP_OKAY;
      case (st_reg.awAddr)
        ctz_pkg::OFF_CTRL: begin
          doStart = st_reg.wStrb[0] && st_reg.wData[ctz_pkg::CTRL_START_BIT];
        end
        ctz_pkg::OFF_LOAD: begin
          axiLoad = st_reg.wStrb[0] && st_reg.wStrb[1];
        end
        ctz_pkg::OFF_STATUS, ctz_pkg::OFF_ORBIT, ctz_pkg::OFF_PEAK: begin
          st_next.bResp = ctz_pkg::RESP_OKAY;
        end
        default: begin
          st_next.bResp = ctz_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.bValid && bready) begin
      st_next.bValid = 1'b0;
      st_next.awRdy = 1'b1;
      st_next.wRdy = 1'b1;
    end

    // axi read channel
    if (arvalid && st_reg.arRdy) begin
      st_next.arRdy = 1'b0;
      st_next.rValid = 1'b1;
      st_next.rResp = ctz_pkg::RESP_OKAY;
      st_next.rData = 32'h00000000;
      case (rdAddr)
        ctz_pkg::OFF_CTRL: begin
          st_next.rData = 32'h00000000;
        end
        ctz_pkg::OFF_STATUS: begin
          st_next.rData[ctz_pkg::STATUS_BUSY_BIT] = (st_reg.state == ctz_pkg::CTZ_COMPUTE);
          st_next.rData[ctz_pkg::STATUS_IO_BIT] = (st_reg.state == ctz_pkg::CTZ_IO);
        end
        ctz_pkg::OFF_ORBIT: begin
          st_next.rData[15:0] = st_reg.orbit;
        end
        ctz_pkg::OFF_PEAK: begin
          st_next.rData[15:0] = st_reg.peak;
        end
        ctz_pkg::OFF_LOAD: begin
          st_next.rData = 32'h00000000;
        end
        default: begin
          st_next.rResp = ctz_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.rValid && rready) begin
      st_next.rValid = 1'b0;
      st_next.arRdy = 1'b1;
    end

    case (st_reg.state)
      ctz_pkg::CTZ_IO: begin
        // line is the host's write enable here
        st_next.busyOe = 1'b0;
        st_next.busyOut = 1'b0;
        if (weRise && pinAddr < ctz_pkg::ITER_BYTES) begin
          st_next.iter[{pinAddr, 3'b000} +: 8] = pinData;
        end
        if (axiLoad && ldAddr < ctz_pkg::ITER_BYTES) begin
          st_next.iter[{ldAddr, 3'b000} +: 8] = ldData;
        end
        if (startRise || doStart) begin
          st_next.state = ctz_pkg::CTZ_COMPUTE;
          st_next.busyOut = 1'b1;
          st_next.busyOe = 1'b1;
          st_next.orbit = ctz_pkg::RST_RESULT;
          st_next.peak = st_next.iter[ctz_pkg::ITER_W-1:ctz_pkg::PEAK_LSB];
        end
      end
      ctz_pkg::CTZ_COMPUTE: begin
        if (isDone) begin
          st_next.state = ctz_pkg::CTZ_IO;
          st_next.busyOut = 1'b0;
          st_next.busyOe = 1'b0;
          // our own busy level must not look like a fresh write enable
          st_next.weSeen = 1'b1;
        end else begin
          st_next.iter = stepVal;
          if (st_reg.orbit != ctz_pkg::ORBIT_MAX) begin
            st_next.orbit = st_reg.orbit + 16'h0001;
          end
          if (topWord > st_reg.peak) begin
            st_next.peak = topWord;
          end
        end
      end
      default: begin
        st_next.state = ctz_pkg::CTZ_IO;
        st_next.busyOe = 1'b0;
        st_next.busyOut = 1'b0;
      end
    endcase

    // byte read port, live in both states
    result = pinSel ? st_reg.peak : st_reg.orbit;
    if (pinAddr == ctz_pkg::RD_ADDR_LO) begin
      st_next.dataOut = result[7:0];
    end else if (pinAddr == ctz_pkg::RD_ADDR_HI) begin
      st_next.dataOut = result[15:8];
    end else begin
      st_next.dataOut = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      st_reg.state <= ctz_pkg::CTZ_IO;
      st_reg.iter <= ctz_pkg::RST_ITER;
      st_reg.orbit <= ctz_pkg::RST_RESULT;
      st_reg.peak <= ctz_pkg::RST_RESULT;
      st_reg.weSeen <= 1'b1;
      st_reg.startSeen <= 1'b1;
      st_reg.awRdy <= 1'b1;
      st_reg.wRdy <= 1'b1;
      st_reg.arRdy <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dataOut = st_reg.dataOut;
  assign weBusyOut = st_reg.busyOut;
  assign weBusyOe = st_reg.busyOe;
  assign awready = st_reg.awRdy;
  assign wready = st_reg.wRdy;
  assign bvalid = st_reg.bValid;
  assign bresp = st_reg.bResp;
  assign arready = st_reg.arRdy;
  assign rvalid = st_reg.rValid;
  assign rdata = st_reg.rData;
  assign rresp = st_reg.rResp;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  busy_drives_line_a: assert property (
    weBusyOe == (st_reg.state == ctz_pkg::CTZ_COMPUTE) && (weBusyOe == weBusyOut))
    else $error("busy line not driven exactly in compute");

  start_enters_compute_a: assert property (
    (st_reg.state == ctz_pkg::CTZ_IO) && startRise |=>
      (st_reg.state == ctz_pkg::CTZ_COMPUTE) && weBusyOut && (st_reg.orbit == 16'h0000))
    else $error("start pin did not begin a run");

  stop_at_one_a: assert property (
    (st_reg.state == ctz_pkg::CTZ_COMPUTE) && (st_reg.iter == ctz_pkg::ITER_ONE) |=>
      (st_reg.state == ctz_pkg::CTZ_IO) && !weBusyOe && $stable(st_reg.orbit))
    else $error("run did not end at one");

  even_halves_a: assert property (
    (st_reg.state == ctz_pkg::CTZ_COMPUTE) && !isDone && !st_reg.iter[0] |=>
      st_reg.iter == ($past(st_reg.iter) >> 1))
    else $error("even value not halved");

  odd_triples_a: assert property (
    (st_reg.state == ctz_pkg::CTZ_COMPUTE) && !isDone && st_reg.iter[0] |=>
      st_reg.iter == (($past(st_reg.iter) << 1) + $past(st_reg.iter) + ctz_pkg::ITER_ONE))
    else $error("odd value not tripled plus one");

  orbit_counts_a: assert property (
    (st_reg.state == ctz_pkg::CTZ_COMPUTE) && !isDone && (st_reg.orbit != ctz_pkg::ORBIT_MAX)
      |=> st_reg.orbit == $past(st_reg.orbit) + 16'h0001)
    else $error("orbit length did not count the step");

  peak_tracks_a: assert property (
    (st_reg.state == ctz_pkg::CTZ_COMPUTE) |=>
      (st_reg.peak >= $past(st_reg.peak)) &&
      (st_reg.peak >= st_reg.iter[ctz_pkg::ITER_W-1:ctz_pkg::PEAK_LSB]))
    else $error("peak lost the upper word maximum");

  byte_load_a: assert property (
    (st_reg.state == ctz_pkg::CTZ_IO) && weRise && (pinAddr < ctz_pkg::ITER_BYTES) |=>
      st_reg.iter[{$past(pinAddr), 3'b000} +: 8] == $past(pinData))
    else $error("written byte not stored at its address");

  read_orbit_a: assert property (
    !pinSel && (pinAddr == ctz_pkg::RD_ADDR_HI) |=> dataOut == $past(st_reg.orbit[15:8]))
    else $error("orbit high byte not on output");

  read_peak_a: assert property (
    pinSel && (pinAddr == ctz_pkg::RD_ADDR_LO) |=> dataOut == $past(st_reg.peak[7:0]))
    else $error("peak low byte not on output");

  run_done_c: cover property (
    (st_reg.state == ctz_pkg::CTZ_COMPUTE) ##1 (st_reg.state == ctz_pkg::CTZ_IO));
  pin_load_c: cover property ((st_reg.state == ctz_pkg::CTZ_IO) && weRise);
  axi_write_c: cover property (bvalid && bready);
  axi_read_c: cover property (rvalid && rready && (rresp == ctz_pkg::RESP_OKAY));
endmodule
`default_nettype wire

// [ctz_pkg.sv]
// constants and state types for the collatz orbit engine
// Summary of operation
// - iterate the collatz map on the loaded integer, stop when value equals one
// - count steps taken to reach one, present as orbit length
// - track largest upper-16-bit iterator value during computation as second result
// - two states, load/read and compute; reset enters load/read
// - load integer one byte per write at the addressed iterator byte
// - start pin rising edge begins iterating and raises busy
// - busy stays high until finished then drops; host reads after fall
// - write enable input and busy output share one two-way line
// - each result limited to 16 bits, read as two bytes
// - select low: orbit low byte at address zero, high byte at one
// - select high: peak value with the same low/high byte addresses
package ctz_pkg;
  localparam int ITER_W = 144;
  localparam int RES_W = 16;
  localparam int PEAK_LSB = 128;
  localparam logic [4:0] ITER_BYTES = 5'h12;
  localparam logic [143:0] ITER_ONE = 144'h1;
  localparam logic [143:0] RST_ITER = 144'h0;
  localparam logic [15:0] RST_RESULT = 16'h0000;
  localparam logic [15:0] ORBIT_MAX = 16'hffff;
  // pin bundle layout through the synchroniser
  localparam int PIN_W = 16;
  localparam int PIN_DATA_LSB = 0;
  localparam int PIN_ADDR_LSB = 8;
  localparam int PIN_SEL = 13;
  localparam int PIN_START = 14;
  localparam int PIN_WE = 15;
  localparam int SYNC_STAGES = 3;
  // byte address of each result byte on the read port
  localparam logic [4:0] RD_ADDR_LO = 5'h00;
  localparam logic [4:0] RD_ADDR_HI = 5'h01;
  // axi4-lite register map
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ORBIT = 8'h08;
  localparam logic [7:0] OFF_PEAK = 8'h0c;
  localparam logic [7:0] OFF_LOAD = 8'h10;
  localparam int CTRL_START_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_IO_BIT = 1;
  localparam int LOAD_DATA_LSB = 0;
  localparam int LOAD_ADDR_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    CTZ_IO = 2'b01,
    CTZ_COMPUTE = 2'b10
  } ctz_state_e;

  typedef struct packed {
    ctz_state_e state;
    logic [143:0] iter;
    logic [15:0] orbit;
    logic [15:0] peak;
    logic weSeen;
    logic startSeen;
    logic [7:0] dataOut;
    logic busyOut;
    logic busyOe;
    logic awRdy;
    logic wRdy;
    logic awHave;
    logic wHave;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic arRdy;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } ctz_core_s;
endpackage

// [ctz_pin_if.sv]
// pin bundle between the engine and its input synchroniser
`timescale 1ns/100ps
`default_nettype none
interface ctz_pin_if #(parameter int W = 16);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface
`default_nettype wire

// [ctz_pin_sync.sv]
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module ctz_pin_sync #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pin bundle
  ctz_pin_if.filt pins
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] clean;
  } ctz_sync_s;

  ctz_sync_s st_reg;
  ctz_sync_s st_next;
  logic [W-1:0] agree;

  always_comb begin
    st_next = st_reg;
    agree = ~(st_reg.s2 ^ st_reg.s3);
    st_next.s1 = pins.raw;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // a bit moves only once stages two and three agree
    st_next.clean = (agree & st_reg.s3) | (~agree & st_reg.clean);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins.clean = st_reg.clean;
endmodule
`default_nettype wire

// [ctz_host_model.sv]
// host-side pin driver for the orbit engine
`timescale 1ns/100ps
`default_nettype none
module ctz_host_model (
  // clock
  input wire logic clk,
  // pins toward the engine
  output logic [7:0] dataIn,
  output logic [4:0] addrIn,
  output logic selIn,
  output logic startIn,
  output logic weDrv,
  output logic weOe,
  // observed
  input wire logic weLine,
  input wire logic [7:0] dataOut
);
  initial begin
    dataIn = 8'h00;
    addrIn = 5'h00;
    selIn = 1'b0;
    startIn = 1'b0;
    weDrv = 1'b0;
    weOe = 1'b0;
  end

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    weOe <= 1'b1;
    weDrv <= 1'b0;
    @(posedge clk);
    dataIn <= d;
    addrIn <= a;
    repeat (4) @(posedge clk);
    weDrv <= 1'b1;
    repeat (6) @(posedge clk);
    weOe <= 1'b0;
    // hold time over, stale byte not kept
    dataIn <= ~d;
    repeat (4) @(posedge clk);
  endtask

  task automatic rd(input logic s, input logic [4:0] a, output logic [7:0] d);
    selIn <= s;
    addrIn <= a;
    repeat (6) @(posedge clk);
    d = dataOut;
  endtask

  task automatic run(output int cyc, output bit ok);
    cyc = 0;
    startIn <= 1'b1;
    for (int i = 0; i < 20 && weLine !== 1'b1; i++) @(posedge clk);
    startIn <= 1'b0;
    // poll busy until it falls, results only after
    for (int i = 0; i < 20000 && weLine === 1'b1; i++) begin
      @(posedge clk);
      cyc++;
    end
    ok = (cyc > 0) && (weLine === 1'b0);
  endtask
endmodule
`default_nettype wire

// [ctz_orbit_engine_tb_top.sv]
// testbench for the collatz orbit engine
`timescale 1ns/100ps
`default_nettype none
module ctz_orbit_engine_tb_top;
  logic clk, rstn, selIn, startIn, weBusyOut, weBusyOe, weDrv, weOe;
  logic [7:0] dataIn, dataOut, awaddr, araddr;
  logic [4:0] addrIn;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  wire weLine;
  int miscompares, n_checks;

  // pull-down on the shared line, so a released line reads idle
  assign weLine = weBusyOe ? weBusyOut : (weOe ? weDrv : 1'b0);

  always #10 clk = ~clk;

  ctz_orbit_engine uut (.clk(clk), .rstn(rstn), .dataIn(dataIn), .addrIn(addrIn),
    .selIn(selIn), .startIn(startIn), .dataOut(dataOut), .weBusyIn(weLine),
    .weBusyOut(weBusyOut), .weBusyOe(weBusyOe), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  ctz_host_model host (.clk(clk), .dataIn(dataIn), .addrIn(addrIn), .selIn(selIn),
    .startIn(startIn), .weDrv(weDrv), .weOe(weOe), .weLine(weLine), .dataOut(dataOut));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
        return;
      end
    end
    check(1'b0, 1'b1);
    results();
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
        return;
      end
    end
    check(1'b0, 1'b1);
    results();
  endtask

  // reference orbit, independent of the design
  function automatic void ref_run(input logic [143:0] v, output logic [15:0] st,
    output logic [15:0] pk);
    st = 16'h0000;
    pk = v[143:128];
    for (int i = 0; i < 20000 && v > 144'h1; i++) begin
      v = v[0] ? v * 144'h3 + 144'h1 : v >> 1;
      st = st + 16'h0001;
      if (v[143:128] > pk) pk = v[143:128];
    end
  endfunction

  task automatic read_res(input logic s, output logic [15:0] r);
    logic [7:0] lo, hi;
    host.rd(s, 5'h00, lo);
    host.rd(s, 5'h01, hi);
    r = {hi, lo};
  endtask

  task automatic s_reset();
    logic [31:0] d;
    logic [1:0] r;
    check(dataOut, 32'h0);
    check(weBusyOe, 32'h0);
    axi_rd(ctz_pkg::OFF_STATUS, d, r);
    check(d, 32'h2);
  endtask

  task automatic s_pin_run(input logic [143:0] v);
    logic [15:0] st, pk, got;
    int cyc;
    bit ok;
    ref_run(v, st, pk);
    for (int i = 0; i < 18; i++) host.wr(5'(i), v[8*i +: 8]);
    // out-of-range byte must not land anywhere
    host.wr(5'h12, 8'hff);
    host.run(cyc, ok);
    check(ok, 32'h1);
    if (!ok) results();
    check(cyc, 32'(st) + 32'h1);
    check(weBusyOe, 32'h0);
    read_res(1'b0, got);
    check(got, st);
    read_res(1'b1, got);
    check(got, pk);
  endtask

  task automatic s_refuse();
    logic [7:0] b;
    host.rd(1'b0, 5'h02, b);
    check(b, 32'h0);
  endtask

  task automatic s_axi();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 18; i++) axi_wr(ctz_pkg::OFF_LOAD, {19'h0, 5'(i), (i == 0) ? 8'h06 : 8'h00}, r);
    axi_wr(ctz_pkg::OFF_CTRL, 32'h1, r);
    check(r, ctz_pkg::RESP_OKAY);
    axi_rd(ctz_pkg::OFF_STATUS, d, r);
    check(d, 32'h1);
    for (int i = 0; i < 100 && d[0] !== 1'b0; i++) axi_rd(ctz_pkg::OFF_STATUS, d, r);
    check(d, 32'h2);
    if (d[0] !== 1'b0) results();
    axi_rd(ctz_pkg::OFF_ORBIT, d, r);
    check(d, 32'h8);
    axi_rd(ctz_pkg::OFF_PEAK, d, r);
    check(d, 32'h0);
    axi_rd(8'h20, d, r);
    check(r, ctz_pkg::RESP_SLVERR);
    axi_wr(8'h24, 32'h1, r);
    check(r, ctz_pkg::RESP_SLVERR);
  endtask

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    s_reset();
    s_pin_run(144'd27);
    s_pin_run((144'h1 << 128) + 144'd27);
    s_pin_run(144'h1);
    s_refuse();
    s_axi();
    results();
  end
endmodule
`default_nettype wire
